// ### hw/pvs_map.svh
// Reset values and counts of the peak and valley slicer.
`ifndef PVS_MAP_SVH
`define PVS_MAP_SVH

// Reference counter reset values.
`define PVS_PEAK_RESET      8'hc0
`define PVS_VALLEY_RESET    8'h40

// Step sizes of the reference counters.
`define PVS_SLOW_ATTACK     8'h02
`define PVS_SLOW_DECAY      8'h01
`define PVS_FAST_ATTACK     8'h04
`define PVS_FAST_DECAY      8'h08

// Decay interval counter loads.
`define PVS_DECAY_ONE       6'h01
`define PVS_DECAY_SLOW      6'h28

// Threshold coefficients in 256ths of the span.
`define PVS_COEF_LOW        8'h32
`define PVS_COEF_MID        8'h86
`define PVS_COEF_HIGH       8'hd9

// Counter limits.
`define PVS_LEVEL_MAX       8'hff
`define PVS_LEVEL_MIN       8'h00

`endif

// ### hw/pvs_pkg.sv
// Types and decode function shared by the slicer modules.
package pvs_pkg;

    // Operating modes, one-hot coded.
    typedef enum logic [3:0] {
        PVS_OFF  = 4'b0001,
        PVS_FAST = 4'b0010,
        PVS_HOLD = 4'b0100,
        PVS_SLOW = 4'b1000
    } pvs_mode_t;

    // Decodes the two mode select levels into a mode.
    function automatic pvs_mode_t pvs_decode(input logic sel_a,
                                             input logic sel_b);
        pvs_mode_t m;
        m = PVS_OFF;
        unique case ({sel_a, sel_b})
            2'b00: m = PVS_OFF;
            2'b01: m = PVS_FAST;
            2'b10: m = PVS_HOLD;
            2'b11: m = PVS_SLOW;
        endcase
        return m;
    endfunction

endpackage

// ### hw/pvs_tracker.sv
// One reference counter with its own decay interval counter.
`timescale 1ns/1ps
`include "pvs_map.svh"
module pvs_tracker
    import pvs_pkg::*;
#(
    parameter bit         IS_VALLEY = 1'b0,
    parameter logic [7:0] RESET_VAL = `PVS_PEAK_RESET
) (
    input  wire logic       clock,      // System clock.
    input  wire logic       rst_n,      // Synchronous reset, active low.
    input  wire logic       step_en,    // One pulse per device clock.
    input  wire logic       track_en,   // Tracking not inhibited.
    input  wire pvs_mode_t  mode,       // Sampled operating mode.
    input  wire logic [7:0] sample,     // Filter output sample.
    output logic      [7:0] level_reg,  // Reference level.
    output logic      [5:0] dcnt_reg    // Decay interval count.
);

    logic       above;
    logic       below;
    logic       attack;
    logic       decay;
    logic [7:0] step_amt;
    logic       step_up;
    logic [5:0] dcnt_next;
    logic [8:0] sum;
    logic [7:0] level_next;

    // Attack and decay directions differ for peak and valley.
    assign above  = sample > level_reg;
    assign below  = sample < level_reg;
    assign attack = IS_VALLEY ? below : above; // R06 R07
    assign decay  = IS_VALLEY ? above : below; // R06 R07

    // Chooses the step and the next decay interval count.
    always_comb begin
        step_amt  = 8'h00;
        step_up   = 1'b0;
        dcnt_next = dcnt_reg;
        if (mode == PVS_HOLD || mode == PVS_OFF) begin
            dcnt_next = `PVS_DECAY_ONE; // R16 R20
        end else if (track_en) begin // R04 R12
            if (attack) begin // R10
                step_amt  = (mode == PVS_FAST) ? `PVS_FAST_ATTACK
                                               : `PVS_SLOW_ATTACK; // R08 R19
                step_up   = !IS_VALLEY;
                dcnt_next = `PVS_DECAY_ONE; // R11
            end else if (decay) begin
                step_up = IS_VALLEY;
                if (mode == PVS_FAST) begin
                    step_amt  = `PVS_FAST_DECAY; // R19
                    dcnt_next = `PVS_DECAY_ONE; // R19
                end else if (dcnt_reg <= `PVS_DECAY_ONE) begin
                    step_amt  = `PVS_SLOW_DECAY; // R09
                    dcnt_next = `PVS_DECAY_SLOW; // R11
                end else begin
                    dcnt_next = dcnt_reg - 6'h01; // R09
                end
            end
        end
    end

    // Saturating step of the level.
    always_comb begin
        sum        = {1'b0, level_reg} + {1'b0, step_amt};
        level_next = level_reg;
        if (step_up) begin
            level_next = sum[8] ? `PVS_LEVEL_MAX : sum[7:0]; // R21
        end else if (level_reg < step_amt) begin
            level_next = `PVS_LEVEL_MIN; // R21
        end else begin
            level_next = level_reg - step_amt;
        end
    end

    // Counter register, advanced once per device clock.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level_reg <= RESET_VAL;
            dcnt_reg  <= `PVS_DECAY_ONE;
        end else if (step_en) begin // R05 R13
            level_reg <= level_next;
            dcnt_reg  <= dcnt_next;
        end
    end

endmodule

// ### hw/pvs_slicer.sv
// Three-threshold comparator giving the Gray coded symbol.
`timescale 1ns/1ps
`include "pvs_map.svh"
module pvs_slicer (
    input  wire logic       clock,     // System clock.
    input  wire logic       rst_n,     // Synchronous reset, active low.
    input  wire logic [7:0] peak,      // Upper reference.
    input  wire logic [7:0] valley,    // Lower reference.
    input  wire logic [7:0] sample,    // Filter output sample.
    output logic      [1:0] sym_reg    // Symbol, bit 0 least significant.
);

    logic [7:0]  span;
    logic [15:0] p_low;
    logic [15:0] p_mid;
    logic [15:0] p_high;
    logic [7:0]  t_low;
    logic [7:0]  t_mid;
    logic [7:0]  t_high;

    // A reversed pair of references gives a zero span.
    assign span   = (peak >= valley) ? peak - valley : 8'h00;
    assign p_low  = span * `PVS_COEF_LOW; // R14
    assign p_mid  = span * `PVS_COEF_MID; // R14
    assign p_high = span * `PVS_COEF_HIGH; // R14
    assign t_low  = valley + p_low[15:8];
    assign t_mid  = valley + p_mid[15:8];
    assign t_high = valley + p_high[15:8];

    // Symbol register, updated every cycle.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sym_reg <= 2'b00;
        end else if (sample < t_low) begin
            sym_reg <= 2'b00; // R15
        end else if (sample < t_mid) begin
            sym_reg <= 2'b10; // R15
        end else if (sample < t_high) begin
            sym_reg <= 2'b11; // R15
        end else begin
            sym_reg <= 2'b01; // R15
        end
    end

endmodule

// ### hw/pvs_top.sv
// Control, mode decode and reference tracking of the symbol slicer.
`timescale 1ns/1ps
`include "pvs_map.svh"
// Function
// R01: Control pins latched on device clock fall.
// R02: Mode pins select off, fast, hold, slow.
// R03: Bandwidth pin selects 1k or 2k filter.
// R04: Track inhibit freezes both counters like hold.
// R05: Separate 8-bit peak and valley counters.
// R06: Peak attacks above level, decays below.
// R07: Valley attacks below level, decays above.
// R08: Slow attack steps by two per clock.
// R09: Slow decay steps one per forty clocks.
// R10: Attack wins over simultaneous decay.
// R11: Interval loads one after attack, forty decay.
// R12: Track inhibit gates decay interval counting.
// R13: Peak and valley have separate interval counters.
// R14: Thresholds at 50, 134, 217 of 256.
// R15: Gray coded two-bit symbol output.
// R16: Off mode stops counters, keeps their values.
// R17: Partner supplies steady 38.4 kHz device clock; the model gives 6.25 MHz (HALF 8).
// R18: Partner drives inhibit from its symbol clock.
// R19: Fast mode steps four attack, eight decay.
// R20: Hold freezes counters, interval loads one.
// R21: Counters saturate at 0 and 255.
module pvs_top
    import pvs_pkg::*;
(
    input  wire logic       clock,            // System clock, 100 MHz.
    input  wire logic       rst_n,            // Synchronous reset.
    input  wire logic       device_clock,     // External device clock pin.
    input  wire logic       bandwidth_select, // Filter bandwidth pin.
    input  wire logic       mode_select_a,    // First mode pin.
    input  wire logic       mode_select_b,    // Second mode pin.
    input  wire logic       track_inhibit,    // High stops tracking.
    input  wire logic       test_select,      // Test pin, sampled only.
    input  wire logic [7:0] filter_output,    // Filtered signal sample.
    output logic            symbol_bit0,      // Symbol low bit.
    output logic            symbol_bit1,      // Symbol high bit.
    output logic            filter_bw_2k,     // High selects 2 kHz cutoff.
    output logic            low_power,        // High in off mode.
    output logic            test_active,      // Sampled test level.
    output logic      [7:0] peak_level,       // Upper reference level.
    output logic      [7:0] valley_level      // Lower reference level.
);

    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic       dclk_prev_reg;
    logic       fall_pulse;
    logic       rise_pulse;
    logic       bw_reg;
    logic       inhibit_reg;
    logic       test_reg;
    pvs_mode_t  mode_reg;
    logic [5:0] peak_dcnt;
    logic [5:0] valley_dcnt;
    logic [1:0] sym;

    // Two-stage synchronisers for the device clock and every control pin; the filter sample is not synchronised.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
        end else begin
            sync1_reg <= {device_clock, bandwidth_select, mode_select_a,
                          mode_select_b, track_inhibit, test_select};
            sync2_reg <= sync1_reg;
        end
    end

    // Edge history of the synchronised device clock.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dclk_prev_reg <= 1'b0;
        end else begin
            dclk_prev_reg <= sync2_reg[5];
        end
    end

    // Falling edge samples controls, rising edge steps the counters.
    assign fall_pulse = dclk_prev_reg & ~sync2_reg[5];
    assign rise_pulse = ~dclk_prev_reg & sync2_reg[5];

    // Control latch, loaded only on the device clock fall.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bw_reg      <= 1'b0;
            inhibit_reg <= 1'b1;
            test_reg    <= 1'b0;
            mode_reg    <= PVS_OFF;
        end else if (fall_pulse) begin // R01
            bw_reg      <= sync2_reg[4];
            mode_reg    <= pvs_decode(sync2_reg[3], sync2_reg[2]); // R02
            inhibit_reg <= sync2_reg[1];
            test_reg    <= sync2_reg[0];
        end
    end

    // Status outputs, registered from the latched controls.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            filter_bw_2k <= 1'b0;
            low_power    <= 1'b1;
            test_active  <= 1'b0;
        end else begin
            filter_bw_2k <= bw_reg; // R03
            low_power    <= (mode_reg == PVS_OFF); // R16
            test_active  <= test_reg;
        end
    end

    // Peak reference counter.
    pvs_tracker #(
        .IS_VALLEY (1'b0),
        .RESET_VAL (`PVS_PEAK_RESET)
    ) u_peak (
        .clock     (clock),
        .rst_n     (rst_n),
        .step_en   (rise_pulse), // R17
        .track_en  (!inhibit_reg), // R04 R18
        .mode      (mode_reg),
        .sample    (filter_output),
        .level_reg (peak_level),
        .dcnt_reg  (peak_dcnt)
    );

    // Valley reference counter.
    pvs_tracker #(
        .IS_VALLEY (1'b1),
        .RESET_VAL (`PVS_VALLEY_RESET)
    ) u_valley (
        .clock     (clock),
        .rst_n     (rst_n),
        .step_en   (rise_pulse),
        .track_en  (!inhibit_reg), // R04
        .mode      (mode_reg),
        .sample    (filter_output),
        .level_reg (valley_level),
        .dcnt_reg  (valley_dcnt)
    );

    // Symbol comparator between the two references.
    pvs_slicer u_slicer (
        .clock   (clock),
        .rst_n   (rst_n),
        .peak    (peak_level),
        .valley  (valley_level),
        .sample  (filter_output),
        .sym_reg (sym)
    );

    // Symbol bits leave straight from the comparator register.
    assign symbol_bit0 = sym[0];
    assign symbol_bit1 = sym[1];

    // Checks of the control and tracking behaviour.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sample_hold_a: assert property ( // R01
        !fall_pulse |=> $stable(mode_reg) && $stable(bw_reg)
                        && $stable(inhibit_reg))
        else $error("Controls changed without a device clock fall.");

    mode_decode_a: assert property ( // R02
        fall_pulse |=> mode_reg == pvs_decode($past(sync2_reg[3]),
                                              $past(sync2_reg[2])))
        else $error("Mode decode does not match the mode pins.");

    bw_select_a: assert property ( // R03
        fall_pulse |-> ##2 filter_bw_2k == $past(sync2_reg[4], 2))
        else $error("Bandwidth output does not follow the pin.");

    inhibit_freeze_a: assert property ( // R04
        inhibit_reg && rise_pulse |=> $stable(peak_level)
                                      && $stable(valley_level))
        else $error("Counters moved while tracking was inhibited.");

    // Hold and off force the interval to one, so only tracking modes keep it.
    interval_gate_a: assert property ( // R12
        inhibit_reg && rise_pulse
        && (mode_reg == PVS_SLOW || mode_reg == PVS_FAST)
        |=> $stable(peak_dcnt) && $stable(valley_dcnt))
        else $error("Decay interval moved while tracking was inhibited.");

    slow_attack_a: assert property ( // R08
        rise_pulse && !inhibit_reg && mode_reg == PVS_SLOW
        && filter_output > peak_level && peak_level < 8'hfe
        |=> peak_level == $past(peak_level) + 8'h02 && peak_dcnt == 6'h01)
        else $error("Slow attack did not step the peak by two.");

    slow_decay_a: assert property ( // R09
        rise_pulse && !inhibit_reg && mode_reg == PVS_SLOW
        && filter_output < peak_level && peak_dcnt == 6'h01
        && peak_level > 8'h00
        |=> peak_level == $past(peak_level) - 8'h01
            && peak_dcnt == 6'h28)
        else $error("Slow decay step or interval reload is wrong.");

    decay_wait_a: assert property ( // R09
        rise_pulse && !inhibit_reg && mode_reg == PVS_SLOW
        && filter_output < peak_level && peak_dcnt > 6'h01
        |=> $stable(peak_level) && peak_dcnt == $past(peak_dcnt) - 6'h01)
        else $error("Peak decayed before its interval ran out.");

    fast_decay_a: assert property ( // R19
        rise_pulse && !inhibit_reg && mode_reg == PVS_FAST
        && filter_output > valley_level && valley_level < 8'hf8
        |=> valley_level == $past(valley_level) + 8'h08
            && valley_dcnt == 6'h01)
        else $error("Fast decay did not step the valley by eight.");

    hold_freeze_a: assert property ( // R20
        rise_pulse && (mode_reg == PVS_HOLD || mode_reg == PVS_OFF)
        |=> $stable(peak_level) && $stable(valley_level)
            && peak_dcnt == 6'h01 && valley_dcnt == 6'h01)
        else $error("Counters moved in hold or off mode.");

    off_power_a: assert property ( // R16
        mode_reg == PVS_OFF && $stable(mode_reg) |=> low_power)
        else $error("Low power flag missing in off mode.");

    peak_saturate_a: assert property ( // R21
        rise_pulse && !inhibit_reg && mode_reg == PVS_FAST
        && filter_output > peak_level && peak_level > 8'hfb
        |=> peak_level == 8'hff)
        else $error("Peak counter wrapped instead of saturating.");

    symbol_gray_a: assert property ( // R15
        filter_output < valley_level && $stable(filter_output)
        && $stable(valley_level) && $stable(peak_level)
        |=> {symbol_bit1, symbol_bit0} == 2'b00)
        else $error("Symbol not zero below the valley.");

    // Valley counter steps, the mirror image of the peak checks.
    valley_attack_a: assert property ( // R07
        rise_pulse && !inhibit_reg && mode_reg == PVS_SLOW
        && filter_output < valley_level && valley_level > 8'h01
        |=> valley_level == $past(valley_level) - 8'h02
            && valley_dcnt == 6'h01)
        else $error("Slow attack did not step the valley down by two.");

    valley_decay_a: assert property ( // R11
        rise_pulse && !inhibit_reg && mode_reg == PVS_SLOW
        && filter_output > valley_level && valley_dcnt == 6'h01
        && valley_level < 8'hff
        |=> valley_level == $past(valley_level) + 8'h01
            && valley_dcnt == 6'h28)
        else $error("Slow valley decay step or reload is wrong.");

    valley_wait_a: assert property ( // R13
        rise_pulse && !inhibit_reg && mode_reg == PVS_SLOW
        && filter_output > valley_level && valley_dcnt > 6'h01
        |=> $stable(valley_level)
            && valley_dcnt == $past(valley_dcnt) - 6'h01)
        else $error("Valley decayed before its interval ran out.");

    // Fast track steps and the limits of both counters.
    fast_attack_a: assert property ( // R19
        rise_pulse && !inhibit_reg && mode_reg == PVS_FAST
        && filter_output > peak_level && peak_level < 8'hfc
        |=> peak_level == $past(peak_level) + 8'h04
            && peak_dcnt == 6'h01)
        else $error("Fast attack did not step the peak by four.");

    peak_floor_a: assert property ( // R21
        rise_pulse && !inhibit_reg && mode_reg == PVS_FAST
        && filter_output < peak_level && peak_level < 8'h08
        |=> peak_level == 8'h00)
        else $error("Peak counter wrapped below zero.");

    valley_floor_a: assert property ( // R21
        rise_pulse && !inhibit_reg && mode_reg == PVS_FAST
        && filter_output < valley_level && valley_level < 8'h04
        |=> valley_level == 8'h00)
        else $error("Valley counter wrapped below zero.");

    valley_ceiling_a: assert property ( // R21
        rise_pulse && !inhibit_reg && mode_reg == PVS_FAST
        && filter_output > valley_level && valley_level > 8'hf7
        |=> valley_level == 8'hff)
        else $error("Valley counter wrapped above full scale.");

    // Control echoes, the top symbol region and quiet counters.
    test_echo_a: assert property ( // R01
        fall_pulse |-> ##2 test_active == $past(sync2_reg[0], 2))
        else $error("Test output does not follow the latched pin.");

    symbol_top_a: assert property ( // R15
        filter_output > peak_level && peak_level >= valley_level
        |=> {symbol_bit1, symbol_bit0} == 2'b01)
        else $error("Symbol not in the top region above the peak.");

    power_exit_a: assert property ( // R16
        mode_reg != PVS_OFF |=> !low_power)
        else $error("Low power flag set outside off mode.");

    level_quiet_a: assert property ( // R05
        !rise_pulse |=> $stable(peak_level) && $stable(valley_level))
        else $error("Counters moved without a device clock rise.");

    // Main scenarios seen in operation.
    cover_slow_decay: cover property (
        rise_pulse && mode_reg == PVS_SLOW && peak_dcnt == 6'h01
        && !inhibit_reg && filter_output < peak_level);

    cover_fast_attack: cover property (
        rise_pulse && mode_reg == PVS_FAST && !inhibit_reg
        && filter_output > peak_level);

    cover_top_symbol: cover property (
        {symbol_bit1, symbol_bit0} == 2'b01);

    cover_hold_entry: cover property (
        mode_reg == PVS_SLOW ##1 mode_reg == PVS_HOLD);

    cover_mid_symbol: cover property (
        {symbol_bit1, symbol_bit0} == 2'b11);

endmodule

// ### sim/pvs_decoder_model.sv
// Paging decoder model that supplies the device clock and track inhibit.
`timescale 1ns/1ps
module pvs_decoder_model #(
    parameter int HALF = 8              // System clocks per clock phase.
) (
    input  wire logic clock,            // System clock.
    input  wire logic rst_n,            // Synchronous reset, active low.
    input  wire logic use_decoder_symbol_clock,       // High routes symbol clock to inhibit.
    input  wire logic inhibit_req,      // Inhibit level otherwise.
    output logic      device_clock,     // Square-wave device clock.
    output logic      track_inhibit     // Track inhibit pin level.
);
    logic [7:0] ph_cnt;
    logic       ph_end;
    logic       rise_odd;
    logic       decoder_symbol_clock;

    // The clock never pauses, because every rate in the slicer scales with it.
    assign ph_end = (ph_cnt == 8'(HALF - 1));
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ph_cnt       <= 8'h00;
            device_clock <= 1'b0;
        end else begin
            ph_cnt <= ph_end ? 8'h00 : ph_cnt + 8'h01;
            if (ph_end) begin
                device_clock <= ~device_clock;
            end
        end
    end

    // The symbol clock toggles on every second device clock rise.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rise_odd             <= 1'b0;
            decoder_symbol_clock <= 1'b0;
        end else if (ph_end && !device_clock) begin
            rise_odd <= ~rise_odd;
            if (rise_odd) begin
                decoder_symbol_clock <= ~decoder_symbol_clock;
            end
        end
    end

    // Tracking is allowed only during part of each symbol.
    assign track_inhibit = use_decoder_symbol_clock ? decoder_symbol_clock
                                      : inhibit_req;
endmodule

// ### sim/pvs_top_tb_top.sv
// Self-checking bench for the peak and valley symbol slicer.
`timescale 1ns/1ps
module pvs_top_tb_top;
    typedef struct packed {
        logic [1:0] ab;
        logic       inh;
        logic       bw;
        logic [7:0] fo;
        logic [7:0] p;
        logic [7:0] v;
    } pvs_row_t;

    logic       clock;
    logic       rst_n;
    logic       device_clock;
    logic       track_inhibit;
    logic       inhibit_req;
    logic       use_decoder_symbol_clock;
    logic       bandwidth_select;
    logic       mode_select_a;
    logic       mode_select_b;
    logic       test_select;
    logic [7:0] filter_output;
    logic       symbol_bit0;
    logic       symbol_bit1;
    logic       filter_bw_2k;
    logic       low_power;
    logic       test_active;
    logic [7:0] peak_level;
    logic [7:0] valley_level;
    int         failures;
    int         checked;

    // Mode pins, inhibit, bandwidth, sample, then expected peak and valley.
    pvs_row_t rows [10] = '{
        '{2'b10, 1'b0, 1'b0, 8'h80, 8'hc0, 8'h40},
        '{2'b11, 1'b0, 1'b1, 8'hf0, 8'hc2, 8'h41},
        '{2'b11, 1'b0, 1'b0, 8'hf0, 8'hc4, 8'h41},
        '{2'b11, 1'b0, 1'b1, 8'h10, 8'hc3, 8'h3f},
        '{2'b11, 1'b0, 1'b0, 8'h10, 8'hc3, 8'h3d},
        '{2'b01, 1'b0, 1'b1, 8'h10, 8'hbb, 8'h39},
        '{2'b01, 1'b0, 1'b0, 8'hf0, 8'hbf, 8'h41},
        '{2'b11, 1'b1, 1'b1, 8'hf0, 8'hbf, 8'h41},
        '{2'b00, 1'b0, 1'b0, 8'hf0, 8'hbf, 8'h41},
        '{2'b10, 1'b0, 1'b1, 8'h10, 8'hbf, 8'h41}
    };

    pvs_decoder_model partner (
        .clock         (clock),
        .rst_n         (rst_n),
        .use_decoder_symbol_clock    (use_decoder_symbol_clock),
        .inhibit_req   (inhibit_req),
        .device_clock  (device_clock),
        .track_inhibit (track_inhibit)
    );

    pvs_top dut (
        .clock            (clock),
        .rst_n            (rst_n),
        .device_clock     (device_clock),
        .bandwidth_select (bandwidth_select),
        .mode_select_a    (mode_select_a),
        .mode_select_b    (mode_select_b),
        .track_inhibit    (track_inhibit),
        .test_select      (test_select),
        .filter_output    (filter_output),
        .symbol_bit0      (symbol_bit0),
        .symbol_bit1      (symbol_bit1),
        .filter_bw_2k     (filter_bw_2k),
        .low_power        (low_power),
        .test_active      (test_active),
        .peak_level       (peak_level),
        .valley_level     (valley_level)
    );

    // The 100 MHz system clock.
    always #5 clock = ~clock;

    // Expected symbol; a sample equal to a threshold counts as above it.
    function automatic logic [1:0] sym_of(input logic [7:0] p, v, fo);
        logic [15:0] sp;
        sp = (p > v) ? {8'h00, p - v} : 16'h0000;
        if (fo < v + 8'((sp * 16'h0032) >> 8)) return 2'b00;
        if (fo < v + 8'((sp * 16'h0086) >> 8)) return 2'b10;
        if (fo < v + 8'((sp * 16'h00d9) >> 8)) return 2'b11;
        return 2'b01;
    endfunction

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic check_lv(input logic [7:0] p, v, fo);
        check(peak_level, p);
        check(valley_level, v);
        check({6'h00, symbol_bit1, symbol_bit0}, {6'h00, sym_of(p, v, fo)});
    endtask

    // Waits for the device clock to reach a level it was not at before.
    task automatic wait_dc(input logic lvl);
        int n;
        n = 0;
        while (device_clock === lvl && n < 60) begin
            @(posedge clock);
            n++;
        end
        while (device_clock !== lvl && n < 60) begin
            @(posedge clock);
            n++;
        end
        if (n >= 60) begin
            failures++;
            test_done();
        end
    endtask

    // One device clock period: pins before the fall, sample before the rise.
    task automatic period(input logic [1:0] ab, input logic inh,
                          input logic bw, input logic [7:0] fo);
        {mode_select_a, mode_select_b} <= ab;
        inhibit_req <= inh;
        bandwidth_select <= bw;
        test_select <= ~bw;
        wait_dc(1'b0);
        filter_output <= fo;
        wait_dc(1'b1);
        repeat (5) @(posedge clock);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        check(peak_level, 8'hc0);
        check(valley_level, 8'h40);
        check({6'h00, symbol_bit1, symbol_bit0}, 8'h00);
        check({7'h00, low_power}, 8'h01);
        check({7'h00, filter_bw_2k}, 8'h00);
        check({7'h00, test_active}, 8'h00);
        rst_n <= 1'b1;
        wait_dc(1'b1);
        repeat (5) @(posedge clock);
    endtask

    // Table cases first, then decay timing, saturation, symbol tracking.
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        inhibit_req = 1'b0;
        use_decoder_symbol_clock = 1'b0;
        bandwidth_select = 1'b0;
        mode_select_a = 1'b0;
        mode_select_b = 1'b0;
        test_select = 1'b0;
        filter_output = 8'h00;
        failures = 0;
        checked = 0;
        @(posedge clock);
        do_reset();
        foreach (rows[i]) begin
            period(rows[i].ab, rows[i].inh, rows[i].bw, rows[i].fo);
            check_lv(rows[i].p, rows[i].v, rows[i].fo);
            check({7'h00, filter_bw_2k}, {7'h00, rows[i].bw});
            check({7'h00, test_active}, {7'h00, ~rows[i].bw});
            check({7'h00, low_power}, {7'h00, rows[i].ab == 2'b00});
        end
        period(2'b11, 1'b0, 1'b0, 8'h80);
        check_lv(8'hbe, 8'h42, 8'h80);
        repeat (20) period(2'b11, 1'b0, 1'b0, 8'h80);
        repeat (5) period(2'b11, 1'b1, 1'b0, 8'h80);
        repeat (19) period(2'b11, 1'b0, 1'b0, 8'h80);
        check_lv(8'hbe, 8'h42, 8'h80);
        period(2'b11, 1'b0, 1'b0, 8'h80);
        check_lv(8'hbd, 8'h43, 8'h80);
        repeat (25) period(2'b01, 1'b0, 1'b0, 8'hff);
        check_lv(8'hff, 8'hff, 8'hff);
        repeat (64) period(2'b01, 1'b0, 1'b0, 8'h00);
        check_lv(8'h00, 8'h00, 8'h00);
        use_decoder_symbol_clock <= 1'b1;
        repeat (8) period(2'b01, 1'b0, 1'b0, 8'hff);
        check_lv(8'h10, 8'h20, 8'hff);
        use_decoder_symbol_clock <= 1'b0;
        do_reset();
        period(2'b10, 1'b0, 1'b0, 8'h80);
        check_lv(8'hc0, 8'h40, 8'h80);
        period(2'b11, 1'b0, 1'b0, 8'h80);
        check_lv(8'hbf, 8'h41, 8'h80);
        period(2'b10, 1'b0, 1'b0, 8'h82);
        check_lv(8'hbf, 8'h41, 8'h82);
        period(2'b10, 1'b0, 1'b0, 8'h59);
        check_lv(8'hbf, 8'h41, 8'h59);
        test_done();
    end
endmodule
